// *** hw/dpsf_host.sv ***
// Purpose: Controller that drives one port of a dual-port memory's semaphore flags
// Assumes: Pin inputs synchronous to CORE_CLK_I; the device has no clock or reset
// Notes:   Semaphore accesses only; memory array traffic is outside this block
//
// Summary of operation
// - Low semaphore_select is chip select; address, enable, read_not_write as SRAM.
// - Hold memory chip enable high while semaphore_select is low.
// - Flags active low: write zero requests, write one releases.
// - Deassert select or output enable between repeated reads.
// - Acquire by writing zero then reading back; never read first.
// - After failed request keep polling or write one to withdraw.
// - No power-up init; software writes one to every flag.

`timescale 1ns/1ps

module dpsf_host (
    // Clock, reset, enable
    input  wire logic                         CORE_CLK_I,
    input  wire logic                         RST_I,
    input  wire logic                         CLK_EN_I,
    // User command port
    input  wire logic                         REQ_VALID_I,
    input  wire dpsf_pkg::dpsf_req_t          REQ_I,
    output logic                              REQ_READY_O,
    output logic                              DONE_O,
    output logic                              GRANTED_O,
    output logic                              FLAG_O,
    // Device pins
    output dpsf_pkg::dpsf_pins_t              PINS_O,
    input  wire logic [dpsf_pkg::DATA_W-1:0]  DATA_I,
    output logic      [dpsf_pkg::DATA_W-1:0]  DATA_O,
    output logic                              DATA_OE_O
);
    import dpsf_pkg::*;

    // Walk of one access, counted in enabled clock cycles:
    //   every pin is registered, so each phase shows one cycle after its state
    //   is entered. The write strobe stands ACCESS_CYC cycles, the select-high
    //   gap RECOVER_CYC cycles and the read strobe ACCESS_CYC cycles. The flag
    //   is taken on the last read edge, while the read strobe still stands.
    // Trade-off: one cycle of latency per command buys glitch-free pins toward
    //   an asynchronous device.
    typedef enum {
        ST_IDLE,
        ST_WR,
        ST_GAP,
        ST_RD,
        ST_DONE
    } dpsf_state_t;

    dpsf_state_t          state_q,  state_d;
    dpsf_cmd_t            cmd_q,    cmd_d;
    logic [IDX_W-1:0]     idx_q,    idx_d;
    logic [CNT_W-1:0]     cnt_q,    cnt_d;
    logic                 wbit_q,   wbit_d;
    logic                 flag_q,   flag_d;
    logic                 grant_q,  grant_d;
    dpsf_pins_t           pins_q,   pins_d;
    logic [DATA_W-1:0]    dout_q,   dout_d;
    logic                 oe_q,     oe_d;

    // Build the semaphore address: only the low index bits mean anything
    function automatic logic [ADDR_W-1:0] sem_addr(input logic [IDX_W-1:0] idx);
        sem_addr = {{(ADDR_W-IDX_W){1'b0}}, idx};
    endfunction : sem_addr

    // Flag as seen on the bus: the device replicates it, so bit zero is enough
    function automatic logic flag_of(input logic [DATA_W-1:0] data);
        flag_of = data[FLAG_BIT];
    endfunction : flag_of

    // Idle pin state puts the port in standby
    function automatic dpsf_pins_t idle_pins();
        idle_pins = '{ce_n: 1'b1, sem_n: 1'b1, rw_n: 1'b1, oe_n: 1'b1, addr: ADDR_RST};
    endfunction : idle_pins

    // Handshake outputs decode the state register; data outputs come from flops
    assign REQ_READY_O = (state_q == ST_IDLE);
    assign DONE_O      = (state_q == ST_DONE);
    assign GRANTED_O   = grant_q;
    assign FLAG_O      = flag_q;
    assign PINS_O      = pins_q;
    assign DATA_O      = dout_q;
    assign DATA_OE_O   = oe_q;

    // Next state: write phase, select-high gap, then read phase
    always_comb begin
        state_d = state_q;
        cmd_d   = cmd_q;
        idx_d   = idx_q;
        cnt_d   = cnt_q;
        wbit_d  = wbit_q;
        flag_d  = flag_q;
        grant_d = grant_q;
        pins_d  = pins_q;
        dout_d  = dout_q;
        oe_d    = oe_q;
        case (state_q)
            ST_IDLE: begin
                pins_d = idle_pins();
                oe_d   = 1'b0;
                if (REQ_VALID_I) begin
                    // Init ignores the given index and walks every flag from zero
                    cmd_d  = REQ_I.cmd;
                    idx_d  = (REQ_I.cmd == DPSF_CMD_INIT) ? IDX_RST : REQ_I.index;
                    cnt_d  = CNT_RST;
                    // Zero requests the token, one releases it
                    wbit_d = (REQ_I.cmd == DPSF_CMD_ACQUIRE) ? 1'b0 : 1'b1;
                    if (REQ_I.cmd == DPSF_CMD_POLL) begin
                        state_d = ST_RD;
                    end else begin
                        state_d = ST_WR;
                    end
                end
            end
            ST_WR: begin
                // Memory enable stays high so the semaphore space is reached
                pins_d.ce_n  = 1'b1;
                pins_d.sem_n = 1'b0;
                pins_d.rw_n  = 1'b0;
                pins_d.oe_n  = 1'b1;
                pins_d.addr  = sem_addr(idx_q);
                dout_d       = DATA_RST;
                dout_d[FLAG_BIT] = wbit_q;
                oe_d         = 1'b1;
                cnt_d        = cnt_q + 4'h1;
                if (cnt_q == CNT_W'(ACCESS_CYC - 1)) begin
                    cnt_d   = CNT_RST;
                    state_d = ST_GAP;
                end
            end
            ST_GAP: begin
                // Select goes high so the next read relatches the flag
                pins_d = idle_pins();
                pins_d.addr = sem_addr(idx_q);
                oe_d   = 1'b0;
                cnt_d  = cnt_q + 4'h1;
                if (cnt_q == CNT_W'(RECOVER_CYC - 1)) begin
                    cnt_d = CNT_RST;
                    if (cmd_q == DPSF_CMD_ACQUIRE) begin
                        state_d = ST_RD;
                    end else if (cmd_q == DPSF_CMD_INIT && idx_q != IDX_LAST) begin
                        idx_d   = idx_q + 3'h1;
                        state_d = ST_WR;
                    end else begin
                        // Release and init assume success: no read follows the last write
                        if (cmd_q != DPSF_CMD_POLL) begin
                            grant_d = 1'b0;
                            flag_d  = 1'b1;
                        end
                        state_d = ST_DONE;
                    end
                end
            end
            ST_RD: begin
                pins_d.ce_n  = 1'b1;
                pins_d.sem_n = 1'b0;
                pins_d.rw_n  = 1'b1;
                pins_d.oe_n  = 1'b0;
                pins_d.addr  = sem_addr(idx_q);
                oe_d         = 1'b0;
                cnt_d        = cnt_q + 4'h1;
                if (cnt_q == CNT_W'(ACCESS_CYC)) begin
                    // Flag is replicated, so bit zero carries it
                    flag_d  = flag_of(DATA_I);
                    grant_d = ~flag_of(DATA_I);
                    cnt_d   = CNT_RST;
                    pins_d  = idle_pins();
                    state_d = ST_DONE;
                end
            end
            ST_DONE: begin
                // One-cycle result pulse; ready returns on the next cycle
                pins_d  = idle_pins();
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Registers; reset acts even with clock enable low, otherwise clock enable low freezes everything
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            state_q <= ST_IDLE;
            cmd_q   <= DPSF_CMD_RELEASE;
            idx_q   <= IDX_RST;
            cnt_q   <= CNT_RST;
            wbit_q  <= 1'b1;
            flag_q  <= 1'b1;
            grant_q <= 1'b0;
            pins_q  <= idle_pins();
            dout_q  <= DATA_RST;
            oe_q    <= 1'b0;
        end else if (CLK_EN_I) begin
            state_q <= state_d;
            cmd_q   <= cmd_d;
            idx_q   <= idx_d;
            cnt_q   <= cnt_d;
            wbit_q  <= wbit_d;
            flag_q  <= flag_d;
            grant_q <= grant_d;
            pins_q  <= pins_d;
            dout_q  <= dout_d;
            oe_q    <= oe_d;
        end
    end

endmodule : dpsf_host

// *** hw/dpsf_pkg.sv ***
// Purpose: Shared constants and carriers for the semaphore port controller
// Assumes: One port of an asynchronous dual-port memory, 40 MHz controller clock
// Notes:   Timing counts are derived from nanosecond figures at the clock period

package dpsf_pkg;

    // Clock and pin timing
    localparam int CLK_PERIOD_NS   = 25;
    localparam int ACCESS_NS       = 50;    // Strobe hold time for one access
    localparam int RECOVER_NS      = 25;    // Select high time between accesses
    localparam int ACCESS_CYC      = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVER_CYC     = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Widths
    localparam int IDX_W           = 3;
    localparam int ADDR_W          = 16;
    localparam int DATA_W          = 18;
    localparam int CNT_W           = 4;
    localparam int NUM_SEM         = 8;

    // Field positions
    localparam int FLAG_BIT        = 0;     // Only bit sampled on a write

    // Reset values
    localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
    localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;
    localparam logic [CNT_W-1:0]  CNT_RST  = 4'h0;
    localparam logic [IDX_W-1:0]  IDX_RST  = 3'h0;
    localparam logic [IDX_W-1:0]  IDX_LAST = 3'h7;

    // Host commands
    typedef enum logic [1:0] {
        DPSF_CMD_ACQUIRE,   // Write zero, then read back
        DPSF_CMD_RELEASE,   // Write one
        DPSF_CMD_POLL,      // Read only, after a failed acquire
        DPSF_CMD_INIT       // Write one to all eight flags
    } dpsf_cmd_t;

    // Pin group driven toward the device
    typedef struct packed {
        logic               ce_n;
        logic               sem_n;
        logic               rw_n;
        logic               oe_n;
        logic [ADDR_W-1:0]  addr;
    } dpsf_pins_t;

    // Request from the user side
    typedef struct packed {
        dpsf_cmd_t          cmd;
        logic [IDX_W-1:0]   index;
    } dpsf_req_t;

endpackage : dpsf_pkg

// *** tb/dpsf_dev_model.sv ***
// Purpose: Behavioural flag device behind the controller's port
// Assumes: Far port worked by the bench through a write strobe
// Notes:   Latches power up as requests; only writes clear them
`timescale 1ns/1ps
module dpsf_dev_model
    import dpsf_pkg::*;
(
    // Near port
    input  wire logic              clk_i,
    input  wire dpsf_pins_t        pins_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic              wdata_oe_i,
    output logic      [DATA_W-1:0] rdata_o,
    // Far port
    input  wire logic              far_we_i,
    input  wire logic [IDX_W-1:0]  far_idx_i,
    input  wire logic              far_bit_i
);
    logic [NUM_SEM-1:0] near_q = '0;
    logic [NUM_SEM-1:0] far_q  = '0;
    logic [1:0]         own_q [NUM_SEM] = '{default: 2'h0};
    logic               act_q = 1'b0;
    logic               val_q = 1'b1;
    // Latch writes, then settle owners; a tie goes to the near side
    always @(posedge clk_i) begin
        if (!pins_i.sem_n && pins_i.ce_n && !pins_i.rw_n && wdata_oe_i) near_q[pins_i.addr[2:0]] = wdata_i[0];
        if (far_we_i) far_q[far_idx_i] = far_bit_i;
        for (int i = 0; i < NUM_SEM; i++) begin
            if ((own_q[i] == 2'h1 && near_q[i]) || (own_q[i] == 2'h2 && far_q[i])) own_q[i] = 2'h0;
            if (own_q[i] == 2'h0) own_q[i] = !near_q[i] ? 2'h1 : (!far_q[i] ? 2'h2 : 2'h0);
        end
        if (!pins_i.sem_n && !pins_i.oe_n && !act_q) val_q <= own_q[pins_i.addr[2:0]] != 2'h1;
        act_q <= !pins_i.sem_n && !pins_i.oe_n;
    end
    // Released bus shows the inverse so stale data never passes
    // Answers in fixed time: there is no wait signal toward the controller
    assign rdata_o = act_q ? {DATA_W{val_q}} : ~{DATA_W{val_q}};
endmodule : dpsf_dev_model

// *** tb/dpsf_host_checker.sv ***
// Purpose: Pin sequencing checks on the semaphore controller
// Assumes: CLK_EN_I dropped only while the controller is idle
// Notes:   Counts follow the fixed write, gap, read walk
`timescale 1ns/1ps
module dpsf_host_checker
    import dpsf_pkg::*;
(
    // Clock and commands
    input wire logic              CORE_CLK_I,
    input wire logic              RST_I,
    input wire logic              CLK_EN_I,
    input wire logic              REQ_VALID_I,
    input wire dpsf_req_t         REQ_I,
    input wire logic              REQ_READY_O,
    input wire logic              DONE_O,
    input wire logic              GRANTED_O,
    input wire logic              FLAG_O,
    // Pins
    input wire dpsf_pins_t        PINS_O,
    input wire logic [DATA_W-1:0] DATA_O,
    input wire logic              DATA_OE_O
);
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (RST_I);
    // Command taken at this edge
    wire tk = REQ_VALID_I && REQ_READY_O && CLK_EN_I;
    // One write or read cycle on the semaphore space
    sequence s_wr(b); !PINS_O.sem_n && !PINS_O.rw_n && DATA_OE_O && DATA_O[FLAG_BIT] == b; endsequence
    sequence s_rd; !PINS_O.sem_n && !PINS_O.oe_n && PINS_O.rw_n && !DATA_OE_O; endsequence
    // Registered pins show each phase one cycle after the state enters it
    property p_acq;
        tk && REQ_I.cmd == DPSF_CMD_ACQUIRE |=> ##1 s_wr(0)[*2] ##1 PINS_O.sem_n ##1 s_rd[*2] ##1 DONE_O;
    endproperty
    property p_rel;
        tk && REQ_I.cmd == DPSF_CMD_RELEASE |=> ##1 s_wr(1)[*2] ##1 (PINS_O.sem_n && DONE_O);
    endproperty
    property p_poll; tk && REQ_I.cmd == DPSF_CMD_POLL |=> ##1 s_rd[*2] ##1 DONE_O; endproperty
    property p_init; tk && REQ_I.cmd == DPSF_CMD_INIT |-> ##2 s_wr(1) ##23 DONE_O; endproperty
    property p_ce; !PINS_O.sem_n |-> PINS_O.ce_n; endproperty
    // Whole address checked, so higher bits must stay zero as well
    property p_idx;
        tk && REQ_I.cmd != DPSF_CMD_INIT |=> ##1 PINS_O.addr == ADDR_W'($past(REQ_I.index, 2));
    endproperty
    property p_gap; s_rd[*2] |=> PINS_O.sem_n; endproperty
    property p_res; DONE_O |-> GRANTED_O != FLAG_O ##1 REQ_READY_O; endproperty
    a_acq: assert property (p_acq) else $error("acquire walk wrong");
    a_rel: assert property (p_rel) else $error("release walk wrong");
    a_poll: assert property (p_poll) else $error("poll walk wrong");
    a_init: assert property (p_init) else $error("init walk wrong");
    a_ce: assert property (p_ce) else $error("chip enable low in flag access");
    a_idx: assert property (p_idx) else $error("flag index wrong");
    a_gap: assert property (p_gap) else $error("select not dropped after read");
    a_res: assert property (p_res) else $error("result pair wrong");
endmodule : dpsf_host_checker

bind dpsf_host dpsf_host_checker chk_u (
    .CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .CLK_EN_I(CLK_EN_I), .REQ_VALID_I(REQ_VALID_I), .REQ_I(REQ_I),
    .REQ_READY_O(REQ_READY_O), .DONE_O(DONE_O), .GRANTED_O(GRANTED_O), .FLAG_O(FLAG_O), .PINS_O(PINS_O),
    .DATA_O(DATA_O), .DATA_OE_O(DATA_OE_O)
);

// *** tb/testbench.sv ***
// Purpose: Self-checking bench for the semaphore controller
// Assumes: Far port of the device driven here
// Notes:   Driver queues results; a monitor pops them on DONE_O
`timescale 1ns/1ps
module testbench;
    import dpsf_pkg::*;
    logic clk = 1'b0, rst = 1'b1, valid = 1'b0, fwe = 1'b0, fbit = 1'b1, en = 1'b1;
    logic rdy, done, gr, flg, doe;
    logic [IDX_W-1:0] fidx = 3'h0, idx;
    logic [DATA_W-1:0] rd, wd;
    dpsf_req_t req = '{DPSF_CMD_POLL, 3'h0};
    dpsf_pins_t pins;
    logic [1:0] exp_q [$];
    int mismatches = 0, n_compared = 0;

    initial forever #12.5 clk = ~clk;
    dpsf_host dut_u (.CORE_CLK_I(clk), .RST_I(rst), .CLK_EN_I(en), .REQ_VALID_I(valid), .REQ_I(req),
        .REQ_READY_O(rdy), .DONE_O(done), .GRANTED_O(gr), .FLAG_O(flg), .PINS_O(pins), .DATA_I(rd),
        .DATA_O(wd), .DATA_OE_O(doe));
    dpsf_dev_model dev_u (.clk_i(clk), .pins_i(pins), .wdata_i(wd), .wdata_oe_i(doe), .rdata_o(rd),
        .far_we_i(fwe), .far_idx_i(fidx), .far_bit_i(fbit));

    task automatic tally_and_finish;
        $display("Compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : tally_and_finish

    // Single comparison point for every checked value
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] seen);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Queue the expected {granted, flag}, hand over the command, wait for completion
    task automatic cmd(input dpsf_cmd_t c, input logic [IDX_W-1:0] i, input logic [1:0] e);
        int n;
        exp_q.push_back(e);
        req = '{c, i};
        valid = 1'b1;
        for (n = 0; n < 50 && rdy !== 1'b1; n++) @(negedge clk);
        if (n == 50) begin
            mismatches++;
            tally_and_finish();
        end
        @(negedge clk);
        valid = 1'b0;
        for (n = 0; n < 50 && done !== 1'b1; n++) @(negedge clk);
        if (n == 50) begin
            mismatches++;
            tally_and_finish();
        end
    endtask : cmd

    // One write from the far port
    task automatic far(input logic [IDX_W-1:0] i, input logic b);
        fidx = i;
        fbit = b;
        fwe = 1'b1;
        @(negedge clk);
        fwe = 1'b0;
        // Let an edge pass so back-to-back calls never retoggle the strobe in one step
        @(negedge clk);
    endtask : far

    // Result monitor
    always @(negedge clk) begin
        if (done === 1'b1) begin
            check("granted_flag", {6'h00, exp_q[0]}, {6'h00, gr, flg});
            check("standby_pins", 8'h03, {6'h00, pins.ce_n, pins.sem_n});
            void'(exp_q.pop_front());
        end
    end

    initial begin
        void'($urandom(97));
        repeat (4) @(negedge clk);
        rst = 1'b0;
        cmd(DPSF_CMD_INIT, 3'h5, 2'b01);
        for (int k = 0; k < NUM_SEM; k++) far(k[IDX_W-1:0], 1'b1);
        $display("Test init done");
        // Clock enable low: a valid command must not be taken nor move chip enable or select out of standby
        en = 1'b0;
        req = '{DPSF_CMD_ACQUIRE, 3'h2};
        valid = 1'b1;
        repeat (3) @(negedge clk);
        check("frozen_ready_done_standby", 8'h0B, {4'h0, rdy, done, pins.ce_n, pins.sem_n});
        valid = 1'b0;
        en = 1'b1;
        @(negedge clk);
        $display("Test freeze done");
        for (int k = 0; k < NUM_SEM; k++) begin
            cmd(DPSF_CMD_ACQUIRE, k[IDX_W-1:0], 2'b10);
            cmd(DPSF_CMD_RELEASE, k[IDX_W-1:0], 2'b01);
        end
        $display("Test every flag done");
        idx = IDX_W'($urandom_range(7));
        cmd(DPSF_CMD_ACQUIRE, idx, 2'b10);
        far(idx, 1'b0);
        cmd(DPSF_CMD_POLL, idx, 2'b10);
        cmd(DPSF_CMD_RELEASE, idx, 2'b01);
        cmd(DPSF_CMD_ACQUIRE, idx, 2'b01);
        far(idx, 1'b1);
        cmd(DPSF_CMD_POLL, idx, 2'b10);
        cmd(DPSF_CMD_POLL, idx, 2'b10);
        cmd(DPSF_CMD_RELEASE, idx, 2'b01);
        $display("Test hand-over done");
        tally_and_finish();
    end
endmodule : testbench
